// File: logic/eeprom_read_pkg.sv
// constants, types and field layouts for the serial eeprom read path
// assumes a single two-wire bus, one core clock and an erased array

package eeprom_read_pkg;

    // ------------------------------------------------------------
    // array geometry and contents
    // ------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam logic [16:0] ADDR_RESET = 17'h0_0000;
    localparam logic [16:0] ADDR_STEP = 17'h0_0001;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int FIFO_DEPTH = 4;

    // ------------------------------------------------------------
    // slave address byte layout
    // ------------------------------------------------------------
    localparam logic [3:0] DEVICE_CODE = 4'ha;
    localparam int CODE_LSB = 4;
    localparam int SEL_HIGH_POS = 3;
    localparam int SEL_LOW_POS = 2;
    localparam int TOP_ADDR_POS = 1;
    localparam int RW_POS = 0;

    // ------------------------------------------------------------
    // bit counting within one byte frame
    // ------------------------------------------------------------
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [3:0] BIT_CNT_STEP = 4'h1;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    // ------------------------------------------------------------
    // byte engine states, gray along the usual path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV = 3'h1,
        ST_ADDR_HI = 3'h3,
        ST_ADDR_LO = 3'h2,
        ST_WDATA = 3'h6,
        ST_TX = 3'h7,
        ST_IGNORE = 3'h5
    } link_state_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] data;
    } fetch_word_t;

    typedef struct packed {
        logic sel_high;
        logic sel_low;
        logic sda;
        logic scl;
    } bus_pins_t;

    localparam bus_pins_t PINS_RESET = 4'h3;

endpackage

// File: logic/byte_prefetch_fifo.sv
// small synchronous fifo holding prefetched array bytes
// assumes depth is a power of two and one clock for both sides
`timescale 1ns/1ps

module byte_prefetch_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // discard everything held
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // handshakes
    // ------------------------------------------------------------
    assign in_ready = (count != (PTR_W + 1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // ------------------------------------------------------------
    // pointers and fill level
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PTR_W'(1);
            end
            if (push && !pop) begin
                count <= count + (PTR_W + 1)'(1);
            end else if (pop && !push) begin
                count <= count - (PTR_W + 1)'(1);
            end
        end
    end

endmodule // byte_prefetch_fifo

// File: logic/serial_eeprom_read_path.sv
// two-wire slave read path of a 128k x 8 serial eeprom
// assumes a bus master drives scl; write engine reports its busy state
`timescale 1ns/1ps

module serial_eeprom_read_path (
    // core clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // two-wire link, scl doubles as the link clock
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // device select straps
    input wire logic device_select_pin_low,
    input wire logic device_select_pin_high,
    // write engine state
    input wire logic write_cycle_busy,
    // status
    output logic standby,
    output logic [16:0] addr_counter
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic rst_core_n;
    logic link_bit;
    logic link_toggle;
    logic [2:0] toggle_sync;
    eeprom_read_pkg::bus_pins_t pins_raw;
    eeprom_read_pkg::bus_pins_t pins_s1;
    eeprom_read_pkg::bus_pins_t pins_s2;
    eeprom_read_pkg::bus_pins_t pins_s3;
    eeprom_read_pkg::bus_pins_t pins;
    eeprom_read_pkg::bus_pins_t pins_prev;
    logic rise_evt;
    logic fall_evt;
    logic start_evt;
    logic stop_evt;
    eeprom_read_pkg::link_state_t state;
    eeprom_read_pkg::link_state_t after_ack;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] byte_now;
    logic [7:0] tx_load;
    logic [7:0] addr_hi;
    logic top_address_bit;
    logic ack_en;
    logic addr_match;
    logic byte_end;
    logic ninth;
    logic pop;
    logic flush;
    logic refill;
    logic [16:0] fetch_addr;
    logic drive_low;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    eeprom_read_pkg::fetch_word_t fifo_in;
    eeprom_read_pkg::fetch_word_t fifo_out;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // natural 17-bit wrap gives the end-of-array rollover
    function automatic logic [16:0] next_addr(input logic [16:0] a);
        return a + eeprom_read_pkg::ADDR_STEP;
    endfunction

    function automatic logic is_receive(
        input eeprom_read_pkg::link_state_t s
    );
        return (s == eeprom_read_pkg::ST_DEV) ||
            (s == eeprom_read_pkg::ST_ADDR_HI) ||
            (s == eeprom_read_pkg::ST_ADDR_LO) ||
            (s == eeprom_read_pkg::ST_WDATA);
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_core_n = rst_pipe[1];

    // ------------------------------------------------------------
    // link domain: capture data on each rising scl
    // ------------------------------------------------------------
    // scl stands still between frames, so the bit is held here
    // and announced to the core by a toggle
    always_ff @(posedge scl or negedge rst_core_n) begin
        if (!rst_core_n) begin
            link_bit <= 1'b1;
            link_toggle <= 1'b0;
        end else begin
            link_bit <= sda_in;
            link_toggle <= ~link_toggle;
        end
    end

    // ------------------------------------------------------------
    // crossings into the core clock
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            toggle_sync <= 3'h0;
        end else begin
            toggle_sync <= {toggle_sync[1:0], link_toggle};
        end
    end

    // link_bit is stable for a whole scl period once the toggle lands
    assign rise_evt = toggle_sync[1] ^ toggle_sync[2];

    assign pins_raw = {device_select_pin_high, device_select_pin_low,
        sda_in, scl};

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pins_s1 <= eeprom_read_pkg::PINS_RESET;
            pins_s2 <= eeprom_read_pkg::PINS_RESET;
            pins_s3 <= eeprom_read_pkg::PINS_RESET;
            pins <= eeprom_read_pkg::PINS_RESET;
            pins_prev <= eeprom_read_pkg::PINS_RESET;
        end else begin
            pins_s1 <= pins_raw;
            pins_s2 <= pins_s1;
            pins_s3 <= pins_s2;
            // a pin changes only once stages two and three agree
            pins <= (pins_s3 & ~(pins_s2 ^ pins_s3)) |
                (pins & (pins_s2 ^ pins_s3));
            pins_prev <= pins;
        end
    end

    // ------------------------------------------------------------
    // bus conditions
    // ------------------------------------------------------------
    assign fall_evt = pins_prev.scl && !pins.scl;
    assign start_evt = pins_prev.scl && pins.scl &&
        pins_prev.sda && !pins.sda;
    assign stop_evt = pins_prev.scl && pins.scl &&
        !pins_prev.sda && pins.sda;

    // ------------------------------------------------------------
    // byte decode
    // ------------------------------------------------------------
    assign byte_now = {rx_shift[6:0], link_bit};
    assign addr_match = (byte_now[7:eeprom_read_pkg::CODE_LSB] ==
            eeprom_read_pkg::DEVICE_CODE) &&
        (byte_now[eeprom_read_pkg::SEL_HIGH_POS] == pins.sel_high) &&
        (byte_now[eeprom_read_pkg::SEL_LOW_POS] == pins.sel_low);
    assign byte_end = rise_evt && !start_evt && !stop_evt &&
        is_receive(state) && (bit_cnt == eeprom_read_pkg::LAST_DATA_BIT);
    assign ninth = rise_evt && !start_evt && !stop_evt &&
        (bit_cnt == eeprom_read_pkg::ACK_BIT);
    assign tx_load = fifo_out_valid ? fifo_out.data :
        eeprom_read_pkg::ERASED_BYTE;
    // the pop commits the byte the master is about to receive
    assign pop = ninth && fifo_out_valid &&
        (((state == eeprom_read_pkg::ST_TX) && !link_bit) ||
        ((state == eeprom_read_pkg::ST_DEV) &&
        (after_ack == eeprom_read_pkg::ST_TX)));

    // ------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state <= eeprom_read_pkg::ST_IDLE;
            after_ack <= eeprom_read_pkg::ST_IDLE;
            bit_cnt <= eeprom_read_pkg::BIT_CNT_RESET;
            rx_shift <= 8'h00;
            tx_shift <= eeprom_read_pkg::ERASED_BYTE;
            addr_hi <= 8'h00;
            top_address_bit <= 1'b0;
            ack_en <= 1'b0;
        end else if (start_evt) begin
            state <= eeprom_read_pkg::ST_DEV;
            bit_cnt <= eeprom_read_pkg::BIT_CNT_RESET;
            ack_en <= 1'b0;
        end else if (stop_evt) begin
            state <= eeprom_read_pkg::ST_IDLE;
            bit_cnt <= eeprom_read_pkg::BIT_CNT_RESET;
            ack_en <= 1'b0;
        end else if (rise_evt) begin
            case (state)
                eeprom_read_pkg::ST_IDLE,
                eeprom_read_pkg::ST_IGNORE: begin
                    bit_cnt <= eeprom_read_pkg::BIT_CNT_RESET;
                end
                eeprom_read_pkg::ST_TX: begin
                    if (bit_cnt != eeprom_read_pkg::ACK_BIT) begin
                        tx_shift <= {tx_shift[6:0], 1'b1};
                        bit_cnt <= bit_cnt + eeprom_read_pkg::BIT_CNT_STEP;
                    end else begin
                        bit_cnt <= eeprom_read_pkg::BIT_CNT_RESET;
                        if (!link_bit) begin
                            tx_shift <= tx_load;
                        end else begin
                            state <= eeprom_read_pkg::ST_IGNORE;
                        end
                    end
                end
                default: begin
                    if (bit_cnt != eeprom_read_pkg::ACK_BIT) begin
                        rx_shift <= byte_now;
                        bit_cnt <= bit_cnt + eeprom_read_pkg::BIT_CNT_STEP;
                    end else begin
                        bit_cnt <= eeprom_read_pkg::BIT_CNT_RESET;
                        ack_en <= 1'b0;
                        state <= after_ack;
                        if (after_ack == eeprom_read_pkg::ST_TX) begin
                            tx_shift <= tx_load;
                        end
                    end
                    if (byte_end) begin
                        ack_en <= 1'b1;
                        case (state)
                            eeprom_read_pkg::ST_DEV: begin
                                // busy write engine: stay silent so the
                                // master can poll
                                if (!addr_match || write_cycle_busy) begin
                                    ack_en <= 1'b0;
                                    after_ack <= eeprom_read_pkg::ST_IGNORE;
                                end else if (
                                    byte_now[eeprom_read_pkg::RW_POS]
                                ) begin
                                    after_ack <= eeprom_read_pkg::ST_TX;
                                end else begin
                                    top_address_bit <= byte_now[
                                        eeprom_read_pkg::TOP_ADDR_POS];
                                    after_ack <= eeprom_read_pkg::ST_ADDR_HI;
                                end
                            end
                            eeprom_read_pkg::ST_ADDR_HI: begin
                                addr_hi <= byte_now;
                                after_ack <= eeprom_read_pkg::ST_ADDR_LO;
                            end
                            default: begin
                                after_ack <= eeprom_read_pkg::ST_WDATA;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // address counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            addr_counter <= eeprom_read_pkg::ADDR_RESET;
        end else if (byte_end && (state == eeprom_read_pkg::ST_ADDR_LO)) begin
            addr_counter <= {top_address_bit, addr_hi, byte_now};
        end else if (byte_end && (state == eeprom_read_pkg::ST_WDATA)) begin
            addr_counter <= next_addr(addr_counter);
        end else if (pop) begin
            // one past the byte just handed out, held through standby
            addr_counter <= next_addr(fifo_out.addr);
        end
    end

    // ------------------------------------------------------------
    // prefetch from the array
    // ------------------------------------------------------------
    // anything that moves the counter outside a pop stales the queue
    assign flush = start_evt || stop_evt || (byte_end &&
        ((state == eeprom_read_pkg::ST_ADDR_LO) ||
        (state == eeprom_read_pkg::ST_WDATA)));
    assign fifo_in_valid = !refill && !flush;
    // write path lives elsewhere; the array here is in delivery state
    assign fifo_in = {fetch_addr, eeprom_read_pkg::ERASED_BYTE};

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            refill <= 1'b1;
            fetch_addr <= eeprom_read_pkg::ADDR_RESET;
        end else if (flush) begin
            refill <= 1'b1;
        end else if (refill) begin
            refill <= 1'b0;
            fetch_addr <= addr_counter;
        end else if (fifo_in_ready) begin
            fetch_addr <= next_addr(fetch_addr);
        end
    end

    byte_prefetch_fifo #(
        .WIDTH($bits(eeprom_read_pkg::fetch_word_t)),
        .DEPTH(eeprom_read_pkg::FIFO_DEPTH)
    ) prefetch (
        .clk(clk),
        .rst_n(rst_core_n),
        .flush(flush),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out)
    );

    // ------------------------------------------------------------
    // open-drain data driver
    // ------------------------------------------------------------
    assign drive_low = (ack_en && (bit_cnt == eeprom_read_pkg::ACK_BIT)) ||
        ((state == eeprom_read_pkg::ST_TX) &&
        (bit_cnt != eeprom_read_pkg::ACK_BIT) && !tx_shift[7]);

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            sda_oe_n <= 1'b1;
            sda_out <= 1'b0;
        end else if (start_evt || stop_evt) begin
            sda_oe_n <= 1'b1;
            sda_out <= 1'b0;
        end else if (fall_evt) begin
            // changes only after scl falls, well inside the low phase
            sda_oe_n <= ~drive_low;
            sda_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            standby <= 1'b1;
        end else begin
            standby <= (state == eeprom_read_pkg::ST_IDLE);
        end
    end

endmodule // serial_eeprom_read_path

// File: testbench/serial_eeprom_read_path_chk.sv
// port assertions for the serial eeprom read path
// assumes one core clock; scl and sda are seen as sampled on clk
`timescale 1ns/1ps

module serial_eeprom_read_path_chk (
    // core clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // two-wire link
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // write engine and status
    input wire logic write_cycle_busy,
    input wire logic standby,
    input wire logic [16:0] addr_counter
);
    logic [5:0] busy_run;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // saturating run of busy cycles, long enough to span one scl bit period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) busy_run <= 6'h00;
        else if (!write_cycle_busy) busy_run <= 6'h00;
        else if (busy_run != 6'h3f) busy_run <= busy_run + 6'h01;
    end

    // ------------------------------------------------------------
    // bus events and checks
    // ------------------------------------------------------------
    sequence s_stop; scl && $rose(sda_in); endsequence
    sequence s_ack; $fell(sda_oe_n); endsequence

    AST_OPEN_DRAIN: assert property (sda_out == 1'h0)
        else $error("sda driven high");
    AST_DRIVE_SCL_LOW: assert property (s_ack |-> !scl && !$past(scl, 2))
        else $error("sda pulled outside scl low");
    AST_ACK_HELD: assert property (s_ack |-> !sda_oe_n [*8])
        else $error("acknowledge too short");
    AST_BUSY_NO_ACK: assert property (s_ack |-> busy_run < 6'h28)
        else $error("ack while write busy");
    AST_IDLE_RELEASED: assert property (standby |-> sda_oe_n)
        else $error("sda held in standby");
    AST_STOP_IDLE: assert property (s_stop |-> ##[1:12] standby)
        else $error("no standby after stop");
    AST_KEEP_COUNT: assert property (standby |-> $stable(addr_counter))
        else $error("counter moved in standby");
    AST_WRAP: assert property ($changed(addr_counter)
        && $past(addr_counter) == 17'h1_ffff |-> addr_counter == 17'h0_0000)
        else $error("counter did not wrap to zero");
endmodule // serial_eeprom_read_path_chk

bind serial_eeprom_read_path serial_eeprom_read_path_chk
    serial_eeprom_read_path_chk_inst (.clk(clk), .rst_n(rst_n), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .write_cycle_busy(write_cycle_busy), .standby(standby),
    .addr_counter(addr_counter));

// File: testbench/two_wire_master_model.sv
// two-wire bus master standing at the far side of the read path
// assumes clk paces it; scl idles high, sda is a pulled-up wired-and
`timescale 1ns/1ps

module two_wire_master_model (
    // pacing clock and device pull-down
    input wire logic clk,
    input wire logic sda_oe_n,
    // bus levels
    output logic scl,
    output logic sda
);
    logic m_low;

    // pulled up unless either party pulls low
    assign sda = sda_oe_n & ~m_low;

    initial begin
        scl = 1'h1;
        m_low = 1'h0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // sda moves in the middle of scl low, or of scl high for start and stop, never at its edges
    task automatic step(input logic c, input logic l, input int n);
        wt(n);
        scl <= c;
        m_low <= l;
    endtask

    // start, also repeated start; scl halves of 16 clk keep 64 ns
    task automatic start();
        step(1'h0, 1'h0, 8);
        step(1'h1, 1'h0, 8);
        step(1'h1, 1'h1, 16);
        step(1'h0, 1'h1, 16);
    endtask

    task automatic stop();
        step(1'h0, 1'h1, 8);
        step(1'h1, 1'h1, 8);
        step(1'h1, 1'h0, 16);
        wt(16);
    endtask

    // eight bits and ack, msb first; a 1 releases sda and samples it
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            step(1'h0, ~d[i], 8);
            step(1'h1, ~d[i], 8);
            wt(8);
            q[i] = sda;
            step(1'h0, ~d[i], 8);
        end
    endtask
endmodule // two_wire_master_model

// File: testbench/serial_eeprom_read_path_tb_top.sv
// self-checking bench for the serial eeprom read path
// assumes the master model makes scl and resolves the sda wire
`timescale 1ns/1ps

`define CHK(a, b) comparisons++; \
    if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end

module serial_eeprom_read_path_tb_top;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic write_cycle_busy = 1'h0;
    logic sel_low = 1'h1;
    logic sel_high = 1'h0;
    logic scl, sda, sda_out, sda_oe_n, standby;
    logic [16:0] addr_counter;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    serial_eeprom_read_path serial_eeprom_read_path_inst (.clk(clk),
        .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .device_select_pin_low(sel_low),
        .device_select_pin_high(sel_high),
        .write_cycle_busy(write_cycle_busy),
        .standby(standby), .addr_counter(addr_counter));
    two_wire_master_model two_wire_master_model_inst (.clk(clk),
        .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

    task automatic finish_test();
        if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // about 12k cycles are needed; a hang is cut well after that
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            finish_test();
        end
    end

    function automatic logic [7:0] dev(input logic t, input logic rw);
        return {eeprom_read_pkg::DEVICE_CODE, sel_high, sel_low, t, rw};
    endfunction

    // read n bytes, after a dummy write when rnd is set
    task automatic rd(input logic [16:0] a, input int n, input logic rnd,
                      input logic [16:0] exp);
        logic [8:0] q;
        if (rnd) begin
            two_wire_master_model_inst.start();
            two_wire_master_model_inst.xfer({dev(a[16], 1'h0), 1'h1}, q);
            `CHK(q[0], 1'h0)
            for (int j = 1; j >= 0; j--) begin
                two_wire_master_model_inst.xfer({a[8*j +: 8], 1'h1}, q);
                `CHK(q[0], 1'h0)
            end
        end
        two_wire_master_model_inst.start();
        two_wire_master_model_inst.xfer({dev(1'h0, 1'h1), 1'h1}, q);
        `CHK(q[0], 1'h0)
        for (int i = 0; i < n; i++) begin
            two_wire_master_model_inst.xfer({8'hff, i == n - 1}, q);
            `CHK(q[8:1], eeprom_read_pkg::ERASED_BYTE)
        end
        two_wire_master_model_inst.stop();
        `CHK(standby, 1'h1)
        `CHK(addr_counter, exp)
    endtask

    // refused address frame: no ack, bus ignored, counter kept
    task automatic refuse(input logic [7:0] d, input logic b);
        logic [8:0] q;
        write_cycle_busy <= b;
        two_wire_master_model_inst.start();
        two_wire_master_model_inst.xfer({d, 1'h1}, q);
        `CHK(q[0], 1'h1)
        two_wire_master_model_inst.xfer(9'h1ff, q);
        `CHK(q, 9'h1ff)
        two_wire_master_model_inst.stop();
        write_cycle_busy <= 1'h0;
        `CHK(addr_counter, 17'h0_a5c7)
    endtask

    // dummy write plus one data byte: all acked, counter steps past it
    task automatic wr(input logic [16:0] a);
        logic [8:0] q;
        logic [23:0] w;
        w = {a[15:0], 8'h3c};
        two_wire_master_model_inst.start();
        two_wire_master_model_inst.xfer({dev(a[16], 1'h0), 1'h1}, q);
        `CHK(q[0], 1'h0)
        for (int j = 2; j >= 0; j--) begin
            two_wire_master_model_inst.xfer({w[8*j +: 8], 1'h1}, q);
            `CHK(q[0], 1'h0)
        end
        two_wire_master_model_inst.stop();
        `CHK(standby, 1'h1)
        `CHK(addr_counter, a + 17'h0_0001)
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        repeat (12) @(posedge clk);
        `CHK(standby, 1'h1)
        `CHK(sda_oe_n, 1'h1)
        `CHK(addr_counter, eeprom_read_pkg::ADDR_RESET)
        rd(17'h0_0000, 1, 1'h0, 17'h0_0001);
        rd(17'h1_fffe, 3, 1'h1, 17'h0_0001);
        rd(17'h1_ffff, 1, 1'h1, 17'h0_0000);
        rd(17'h0_a5c3, 2, 1'h1, 17'h0_a5c5);
        rd(17'h0_0000, 2, 1'h0, 17'h0_a5c7);
        refuse(8'hb5, 1'h0);
        refuse(8'ha9, 1'h0);
        refuse(dev(1'h0, 1'h1), 1'h1);
        // straps swapped: the old select bits must now be refused
        sel_high <= 1'h1;
        sel_low <= 1'h0;
        refuse(8'ha5, 1'h0);
        rd(17'h0_0000, 1, 1'h0, 17'h0_a5c8);
        wr(17'h1_ffff);
        finish_test();
    end
endmodule // serial_eeprom_read_path_tb_top
